//--- overrange_clock_pkg.sv
/*
 * Shared constants and types for the channel D over-range / clock output pin.
 * Assumes one 100 MHz system clock and that SPI settings arrive already
 * registered in that clock domain.
 */
package overrange_clock_pkg;

   // ***********************************************
   // Clock selection encodings
   // ***********************************************
   localparam logic [1:0] CFG_OFF  = 2'h0;   // Pin carries the over-range flag.
   localparam logic [1:0] DIV_NONE = 2'h1;   // Undivided reference copy.
   localparam logic [1:0] DIV_BY2  = 2'h2;   // Reference divided by two.
   localparam logic [1:0] DIV_BY4  = 2'h3;   // Reference divided by four.

   // ***********************************************
   // Reset values and counts
   // ***********************************************
   localparam logic [1:0] DIV_CNT_RESET  = 2'h0;
   localparam logic       PIN_RESET      = 1'h0;
   localparam logic [2:0] SYNC_RESET     = 3'h0;
   localparam int         MIN_PULSE_FLOOR = 1;   // A pulse never lasts under one cycle.

   // Pin source selection for a shared output pin.
   typedef enum logic {
      SEL_RANGE = 1'b0,
      SEL_CLOCK = 1'b1
   } pin_sel_t;

   // Asynchronous pin inputs, carried together through the synchroniser.
   typedef struct packed {
      logic       pll_ref;     // PLL reference clock level.
      logic       pll_en;      // PLL enable pin.
      logic       pd;          // Power-down pin.
      logic [1:0] cfg;         // Two-bit clock output configuration pins.
      logic       quad;        // Quad-channel configuration strap.
   } pins_t;

   localparam int PINS_W = $bits(pins_t);

endpackage

//--- overrange_clock_out_mux_d.sv
/*
 * Channel D output pin logic: fast over-range flag with programmable threshold
 * and minimum pulse, or a copy (undivided, /2, /4) of the PLL reference clock.
 * Assumes the channel D sample and SPI settings are synchronous to ref_clk_in,
 * and that the reference clock is much slower than ref_clk_in so it can be
 * sampled as an ordinary pin.
 */
`timescale 1ns/1ns
module overrange_clock_out_mux_d #(
   parameter int SAMPLE_W = 9,                       // Channel D sample width.
   parameter int MINP_W   = 8                        // Minimum pulse setting width.
) (
   input  wire logic                ref_clk_in,              // 100 MHz system clock.
   input  wire logic                resetn_in,               // Asynchronous reset, active low.
   input  wire logic [SAMPLE_W-1:0] chan_d_level_in,         // Channel D input magnitude.
   input  wire logic                chan_c_range_in,         // Channel C over-range flag from core.
   input  wire logic [SAMPLE_W-1:0] overrange_threshold_in,  // Over-range threshold.
   input  wire logic [MINP_W-1:0]   overrange_min_pulse_in,  // Minimum pulse length in cycles.
   input  wire logic                spi_clk_override_in,     // SPI override of clock selection.
   input  wire logic                spi_clk_disable_in,      // SPI disable of channel D clock.
   input  wire logic [1:0]          spi_div_sel_in,          // SPI division select.
   input  wire logic                pll_ref_pin_in,          // PLL reference clock pin.
   input  wire logic                pll_enable_in,           // PLL enable pin.
   input  wire logic                power_down_pin_in,       // Power-down pin.
   input  wire logic [1:0]          clock_out_config_in,     // Clock output configuration pins.
   input  wire logic                quad_config_in,          // Quad-channel strap pin.
   output logic                     chan_d_range_flag_pin_out, // Channel D pin.
   output logic                     chan_c_range_flag_pin_out, // Channel C pin.
   output logic                     pll_ref_clock_out        // PLL reference clock output.
);

   // ***********************************************
   // Reset release
   // ***********************************************
   logic rst_meta;
   logic rst_n;

   // Two flops release the reset cleanly against the clock.
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ***********************************************
   // Pin synchroniser
   // ***********************************************
   overrange_clock_pkg::pins_t s1, s2, s3, filt, next_filt, raw;

   assign raw = '{pll_ref: pll_ref_pin_in, pll_en: pll_enable_in, pd: power_down_pin_in,
                  cfg: clock_out_config_in, quad: quad_config_in};

   // A bit changes only when the second and third stages agree.
   always_comb begin
      next_filt = (s3 & ~(s2 ^ s3)) | (filt & (s2 ^ s3));
   end

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         s1   <= '0;
         s2   <= '0;
         s3   <= '0;
         filt <= '0;
      end else begin
         s1   <= raw;
         s2   <= s1;
         s3   <= s2;
         filt <= next_filt;
      end
   end

   // ***********************************************
   // Reference divider
   // ***********************************************
   logic       ref_q;
   logic [1:0] div_cnt, next_div_cnt;
   logic       ref_rise;

   // Picks the divided reference level for one division code.
   function automatic logic div_level(input logic [1:0] div, input logic [1:0] cnt, input logic ref_lvl);
      unique case (div)
         overrange_clock_pkg::DIV_BY2: div_level = cnt[0];
         overrange_clock_pkg::DIV_BY4: div_level = cnt[1];
         default:                      div_level = ref_lvl;
      endcase
   endfunction

   assign ref_rise = filt.pll_ref & ~ref_q;

   // One counter serves both pins so their divided clocks stay in phase.
   always_comb begin
      next_div_cnt = div_cnt;
      if (filt.pd || !filt.pll_en) begin
         next_div_cnt = overrange_clock_pkg::DIV_CNT_RESET;
      end else if (ref_rise) begin
         next_div_cnt = div_cnt + 2'h1;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         ref_q   <= 1'b0;
         div_cnt <= overrange_clock_pkg::DIV_CNT_RESET;
      end else begin
         ref_q   <= filt.pll_ref;
         div_cnt <= next_div_cnt;
      end
   end

   // ***********************************************
   // Over-range detection and pulse stretch
   // ***********************************************
   logic              exceed;
   logic [MINP_W-1:0] pulse_cnt, next_pulse_cnt;
   logic              next_range;

   assign exceed = chan_d_level_in > overrange_threshold_in;

   // A crossing reloads the stretch so the flag lasts the programmed minimum.
   always_comb begin
      next_pulse_cnt = pulse_cnt;
      if (exceed) begin
         next_pulse_cnt = (overrange_min_pulse_in == '0) ? '0 : overrange_min_pulse_in - 1'b1;
      end else if (pulse_cnt != '0) begin
         next_pulse_cnt = pulse_cnt - 1'b1;
      end
      next_range = filt.quad & (exceed | (pulse_cnt != '0));
   end

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         pulse_cnt <= '0;
      end else begin
         pulse_cnt <= next_pulse_cnt;
      end
   end

   // ***********************************************
   // Clock requests and output muxes
   // ***********************************************
   logic                          pll_live, c_clk_on, d_clk_req;
   logic [1:0]                    div_c, div_d;
   logic                          c_src, d_src;
   overrange_clock_pkg::pin_sel_t sel_c, sel_d, next_sel_c, next_sel_d;
   logic                          next_pin_c, next_pin_d, next_ref_out;

   // Selections are held until both the pin and the outgoing source are low,
   // trading a few cycles of latency for a glitch-free handover.
   always_comb begin
      pll_live  = filt.pll_en & ~filt.pd;
      c_clk_on  = pll_live & ((filt.cfg != overrange_clock_pkg::CFG_OFF) | spi_clk_override_in);
      d_clk_req = c_clk_on & ~spi_clk_disable_in;
      div_c     = spi_clk_override_in ? spi_div_sel_in : filt.cfg;
      div_d     = spi_clk_override_in ? spi_div_sel_in : overrange_clock_pkg::DIV_NONE;
      c_src     = c_clk_on & div_level(div_c, div_cnt, ref_q);
      d_src     = d_clk_req & div_level(div_d, div_cnt, ref_q);
      next_pin_c = (sel_c == overrange_clock_pkg::SEL_CLOCK) ? c_src : chan_c_range_in;
      next_pin_d = (sel_d == overrange_clock_pkg::SEL_CLOCK) ? d_src : next_range;
      next_sel_c = sel_c;
      next_sel_d = sel_d;
      if (!chan_c_range_flag_pin_out && !next_pin_c) begin
         next_sel_c = c_clk_on ? overrange_clock_pkg::SEL_CLOCK : overrange_clock_pkg::SEL_RANGE;
      end
      if (!chan_d_range_flag_pin_out && !next_pin_d) begin
         next_sel_d = d_clk_req ? overrange_clock_pkg::SEL_CLOCK : overrange_clock_pkg::SEL_RANGE;
      end
      next_ref_out = pll_live & ref_q;
   end

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         sel_c                     <= overrange_clock_pkg::SEL_RANGE;
         sel_d                     <= overrange_clock_pkg::SEL_RANGE;
         chan_c_range_flag_pin_out <= overrange_clock_pkg::PIN_RESET;
         chan_d_range_flag_pin_out <= overrange_clock_pkg::PIN_RESET;
         pll_ref_clock_out         <= overrange_clock_pkg::PIN_RESET;
      end else begin
         sel_c                     <= next_sel_c;
         sel_d                     <= next_sel_d;
         chan_c_range_flag_pin_out <= next_pin_c;
         chan_d_range_flag_pin_out <= next_pin_d;
         pll_ref_clock_out         <= next_ref_out;
      end
   end

   // ***********************************************
   // Assertions
   // ***********************************************
   logic [MINP_W:0]   hi_run;
   logic [MINP_W:0]   last_load;

   // Helper: run length of the stretched flag and the minimum last loaded.
   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         hi_run    <= '0;
         last_load <= '0;
      end else begin
         hi_run    <= next_range ? ((&hi_run) ? hi_run : hi_run + 1'b1) : '0;
         if (exceed) begin
            last_load <= (overrange_min_pulse_in == '0) ? (MINP_W+1)'(overrange_clock_pkg::MIN_PULSE_FLOOR)
                                                        : {1'b0, overrange_min_pulse_in};
         end
      end
   end
   property p_flag_on_exceed;
      @(posedge ref_clk_in) disable iff (!rst_n)
      (sel_d == overrange_clock_pkg::SEL_RANGE && filt.quad && exceed) |=> chan_d_range_flag_pin_out;
   endproperty
   a_flag_on_exceed: assert property (p_flag_on_exceed) else $error("flag missed exceed");

   property p_min_pulse;
      @(posedge ref_clk_in) disable iff (!rst_n)
      (hi_run != '0 && !next_range) |-> hi_run >= last_load;
   endproperty
   a_min_pulse: assert property (p_min_pulse) else $error("flag pulse too short");

   property p_quad_only;
      @(posedge ref_clk_in) disable iff (!rst_n)
      (!filt.quad && sel_d == overrange_clock_pkg::SEL_RANGE) |=> !chan_d_range_flag_pin_out;
   endproperty
   a_quad_only: assert property (p_quad_only) else $error("flag outside quad mode");

   property p_back_to_range;
      @(posedge ref_clk_in) disable iff (!rst_n)
      (!d_clk_req && !chan_d_range_flag_pin_out) |=> ##[0:2] sel_d == overrange_clock_pkg::SEL_RANGE;
   endproperty
   a_back_to_range: assert property (p_back_to_range) else $error("pin not back to flag");

   property p_clock_needs_enable;
      @(posedge ref_clk_in) disable iff (!rst_n)
      (chan_d_range_flag_pin_out && sel_d == overrange_clock_pkg::SEL_CLOCK) |-> $past(filt.pll_en);
   endproperty
   a_clock_needs_enable: assert property (p_clock_needs_enable) else $error("clock without PLL");

   property p_undivided;
      @(posedge ref_clk_in) disable iff (!rst_n)
      (sel_d == overrange_clock_pkg::SEL_CLOCK && d_clk_req && !spi_clk_override_in)
         |=> chan_d_range_flag_pin_out == $past(filt.pll_ref, 2);
   endproperty
   a_undivided: assert property (p_undivided) else $error("D clock not reference copy");

   property p_div4;
      @(posedge ref_clk_in) disable iff (!rst_n)
      (sel_d == overrange_clock_pkg::SEL_CLOCK && d_clk_req && div_d == overrange_clock_pkg::DIV_BY4)
         |=> chan_d_range_flag_pin_out == $past(div_cnt[1]);
   endproperty
   a_div4: assert property (p_div4) else $error("D clock not divided by four");

   property p_d_needs_c;
      @(posedge ref_clk_in) disable iff (!rst_n)
      (chan_d_range_flag_pin_out && sel_d == overrange_clock_pkg::SEL_CLOCK) |-> $past(c_clk_on);
   endproperty
   a_d_needs_c: assert property (p_d_needs_c) else $error("D clock without C clock");

   property p_power_down;
      @(posedge ref_clk_in) disable iff (!rst_n)
      filt.pd |=> !pll_ref_clock_out && !(sel_c == overrange_clock_pkg::SEL_CLOCK && chan_c_range_flag_pin_out);
   endproperty
   a_power_down: assert property (p_power_down) else $error("clock runs in power-down");

   property p_c_div2;
      @(posedge ref_clk_in) disable iff (!rst_n)
      (sel_c == overrange_clock_pkg::SEL_CLOCK && c_clk_on && div_c == overrange_clock_pkg::DIV_BY2)
         |=> chan_c_range_flag_pin_out == $past(div_cnt[0]);
   endproperty
   a_c_div2: assert property (p_c_div2) else $error("C clock not divided by two");

   property p_switch_low;
      @(posedge ref_clk_in) disable iff (!rst_n)
      $changed(sel_d) |-> !$past(chan_d_range_flag_pin_out) && !chan_d_range_flag_pin_out;
   endproperty
   a_switch_low: assert property (p_switch_low) else $error("switch while pin high");

   c_flag_pulse: cover property (@(posedge ref_clk_in) disable iff (!rst_n) $fell(chan_d_range_flag_pin_out));
   c_to_clock:   cover property (@(posedge ref_clk_in) disable iff (!rst_n)
                                 $rose(sel_d == overrange_clock_pkg::SEL_CLOCK));
   c_div4_run:   cover property (@(posedge ref_clk_in) disable iff (!rst_n)
                                 div_d == overrange_clock_pkg::DIV_BY4 && chan_d_range_flag_pin_out);

endmodule // overrange_clock_out_mux_d

//--- range_clock_sink.sv
/*
 * Far-side receiver of the channel C, channel D and reference clock pins.
 * Assumes all pins are registered on the same clock that it samples with.
 */
`timescale 1ns/1ns
module range_clock_sink (
   input  wire logic clk_in,          // Sampling clock.
   input  wire logic clear_in,        // Clears the edge counters.
   input  wire logic mon_en_in,       // Enables the high-run watch on channel D.
   input  wire logic d_pin_in,        // Channel D pin.
   input  wire logic c_pin_in,        // Channel C pin.
   input  wire logic ref_pin_in,      // Reference clock pin.
   output int        d_edges_out,     // Rising edges seen on channel D.
   output int        c_edges_out,     // Rising edges seen on channel C.
   output int        ref_edges_out,   // Rising edges seen on the reference pin.
   output int        min_run_out      // Shortest high run on D while watched.
);
   logic d_q = 1'b0;
   logic c_q = 1'b0;
   logic r_q = 1'b0;
   int   run = 0;
   initial min_run_out = 255;
   // Counts edges and runs; a short high run in clock mode means a glitch on the switch.
   always @(posedge clk_in) begin
      d_q <= d_pin_in;
      c_q <= c_pin_in;
      r_q <= ref_pin_in;
      run <= d_pin_in ? run + 1 : 0;
      if (d_q && !d_pin_in && mon_en_in && run < min_run_out) begin
         min_run_out <= run;
      end
      if (clear_in) begin
         d_edges_out   <= 0;
         c_edges_out   <= 0;
         ref_edges_out <= 0;
      end else begin
         d_edges_out   <= d_edges_out + int'(d_pin_in && !d_q);
         c_edges_out   <= c_edges_out + int'(c_pin_in && !c_q);
         ref_edges_out <= ref_edges_out + int'(ref_pin_in && !r_q);
      end
   end
endmodule // range_clock_sink

//--- tb.sv
/*
 * Self-checking bench for the channel D over-range and clock output pin.
 * Assumes a reference clock far slower than the system clock, made here.
 */
`timescale 1ns/1ns
module tb;
   // ***********************************************
   // Stimulus and observation
   // ***********************************************
   localparam int REFH = 4;                      // Reference half period in cycles.
   localparam int WIN  = 160;                    // Edge counting window.
   localparam int EXPU = WIN / (2 * REFH);       // Undivided edges per window.
   typedef struct {
      logic [1:0] cfg; logic ovr, dis; logic [1:0] div; logic en, pd;
      logic [8:0] lvl, thr; logic [7:0] minp; int expp, dd, dc, dr;
   } row_t;
   logic clk = 1'b0, resetn = 1'b0, ovr = 1'b0, dis = 1'b0, pref = 1'b0, en = 1'b1, pd = 1'b0;
   logic quad = 1'b1, crange = 1'b0, clr = 1'b0, mon_en = 1'b0;
   logic [8:0] lvl = 9'h000, thr = 9'h000;
   logic [7:0] minp = 8'h00;
   logic [1:0] div = 2'h0, cfg = 2'h0;
   logic d_pin, c_pin, r_pin;
   logic [31:0] n;
   int d_e, c_e, r_e, min_run, error_cnt = 0, check_count = 0;
   row_t rows[14] = '{
      '{2'h1, 0, 0, 2'h0, 1, 0, 9'h000, 9'h000, 8'h00, 0, 1, 1, 1},
      '{2'h2, 0, 0, 2'h0, 1, 0, 9'h000, 9'h000, 8'h00, 0, 1, 2, 1},
      '{2'h3, 0, 0, 2'h0, 1, 0, 9'h000, 9'h000, 8'h00, 0, 1, 4, 1},
      '{2'h0, 1, 0, 2'h2, 1, 0, 9'h000, 9'h000, 8'h00, 0, 2, 2, 1},
      '{2'h0, 1, 0, 2'h3, 1, 0, 9'h000, 9'h000, 8'h00, 0, 4, 4, 1},
      '{2'h0, 1, 0, 2'h0, 1, 0, 9'h000, 9'h000, 8'h00, 0, 1, 1, 1},
      '{2'h1, 0, 1, 2'h0, 1, 0, 9'h000, 9'h000, 8'h00, 0, 0, 1, 1},
      '{2'h1, 0, 0, 2'h0, 0, 0, 9'h000, 9'h000, 8'h00, 0, 0, 0, 0},
      '{2'h1, 0, 0, 2'h0, 1, 1, 9'h000, 9'h000, 8'h00, 0, 0, 0, 0},
      '{2'h0, 0, 0, 2'h0, 1, 0, 9'h00a, 9'h009, 8'h03, 3, 0, 0, 1},
      '{2'h0, 0, 0, 2'h0, 1, 0, 9'h009, 9'h009, 8'h03, 0, 0, 0, 1},
      '{2'h0, 0, 0, 2'h0, 1, 0, 9'h00a, 9'h009, 8'h00, 1, 0, 0, 1},
      '{2'h0, 0, 0, 2'h0, 1, 0, 9'h1ff, 9'h000, 8'h01, 1, 0, 0, 1},
      '{2'h0, 0, 0, 2'h0, 1, 0, 9'h0c8, 9'h064, 8'h08, 8, 0, 0, 1}};

   overrange_clock_out_mux_d dut (.ref_clk_in(clk), .resetn_in(resetn), .chan_d_level_in(lvl),
      .chan_c_range_in(crange), .overrange_threshold_in(thr), .overrange_min_pulse_in(minp),
      .spi_clk_override_in(ovr), .spi_clk_disable_in(dis), .spi_div_sel_in(div), .pll_ref_pin_in(pref),
      .pll_enable_in(en), .power_down_pin_in(pd), .clock_out_config_in(cfg), .quad_config_in(quad),
      .chan_d_range_flag_pin_out(d_pin), .chan_c_range_flag_pin_out(c_pin), .pll_ref_clock_out(r_pin));
   range_clock_sink sink (.clk_in(clk), .clear_in(clr), .mon_en_in(mon_en), .d_pin_in(d_pin),
      .c_pin_in(c_pin), .ref_pin_in(r_pin), .d_edges_out(d_e), .c_edges_out(c_e),
      .ref_edges_out(r_e), .min_run_out(min_run));

   // Clock and reference; the reference toggles on the falling edge like any other input.
   initial begin
      forever #5 clk = ~clk;
   end
   always begin
      repeat (REFH) @(negedge clk);
      pref = ~pref;
   end

   // ***********************************************
   // Helpers
   // ***********************************************
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %0d seen %0d", name, exp, seen);
      end
   endtask
   // Edge counts may slip by one at the window borders.
   function automatic logic near(input int v, input int e);
      return (v + 1 >= e) && (v <= e + 1);
   endfunction
   // One or two exceed cycles two apart, then the high cycles of D are counted.
   task automatic pulse(input logic [8:0] v, input bit twice, output logic [31:0] cnt);
      int i;
      cnt = 0;
      for (i = 0; i < 28; i++) begin
         @(negedge clk);
         cnt = cnt + {31'h0, d_pin};
         lvl = (i == 0 || (twice && i == 2)) ? v : 9'h000;
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ***********************************************
   // Sequence
   // ***********************************************
   initial begin
      repeat (10) @(negedge clk);
      check("pins_in_reset", {29'h0, d_pin, c_pin, r_pin}, 32'h0);
      resetn = 1'b1;
      repeat (6) @(negedge clk);
      foreach (rows[k]) begin
         {cfg, ovr, dis, div, en, pd} = {rows[k].cfg, rows[k].ovr, rows[k].dis, rows[k].div, rows[k].en, rows[k].pd};
         // The glitch watch covers the settled window only; a division change may cut one period short.
         {thr, minp} = {rows[k].thr, rows[k].minp};
         repeat (16) @(negedge clk);
         clr = 1'b1;
         @(negedge clk) {clr, mon_en} = {1'b0, rows[k].dd != 0};
         repeat (WIN) @(negedge clk);
         check("d_edges", near(d_e, rows[k].dd ? EXPU / rows[k].dd : 0), 1);
         check("c_edges", near(c_e, rows[k].dc ? EXPU / rows[k].dc : 0), 1);
         check("ref_edges", near(r_e, rows[k].dr ? EXPU / rows[k].dr : 0), 1);
         mon_en = 1'b0;
         if (rows[k].cfg == 2'h0 && !rows[k].ovr) begin
            pulse(rows[k].lvl, 1'b0, n);
            check("pulse_len", n, rows[k].expp);
         end
         pd = 1'b0;
         $display("row %0d done", k);
      end
      check("switch_glitch", min_run >= REFH - 1, 1);
      // Two exceed cycles two apart with a three cycle minimum must stretch to five.
      {thr, minp} = {9'h009, 8'h03};
      pulse(9'h00a, 1'b1, n);
      check("reload_len", n, 32'd5);
      crange = 1'b1;
      @(negedge clk) crange = 1'b1;
      @(negedge clk) check("c_flag", {31'h0, c_pin}, 1);
      crange = 1'b0;
      quad = 1'b0;
      repeat (8) @(negedge clk);
      pulse(9'h00a, 1'b0, n);
      check("dual_flag", n, 0);
      $display("hand tests done");
      resetn = 1'b0;
      @(negedge clk) check("pins_mid_reset", {29'h0, d_pin, c_pin, r_pin}, 32'h0);
      close_out();
   end
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      close_out();
   end
endmodule // tb
